/* File: rtl/sth_host.sv */
// host controller driving the serial target through its select, clock and data pins
`timescale 1ns/100ps
module sth_host
	import sth_pkg::*;
(
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_ARST_N,
	input  wire logic [5:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [5:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	input  wire logic        I_TARGET_MISO,
	output logic             O_TARGET_SELECT_N,
	output logic             O_TARGET_SERIAL_CLOCK,
	output logic             O_TARGET_MOSI,
	output logic             O_BUSY
);

	typedef struct packed {
		sth_phase_t  ph;
		logic [31:0] ctrl;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] tstat;
		logic [31:0] rdata;
		logic [7:0]  div;
		logic        done;
		logic        sel_n;
		logic        start;
		logic [7:0]  txb;
		logic [3:0]  idx;
		logic [5:0]  rcnt;
		logic        aw_ok;
		logic        w_ok;
		logic [5:0]  awa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rd;
		logic        init;
	} sth_host_t;

	sth_host_t st, next_st;
	sth_link_if lnk ();
	logic       miso_m, miso_s;
	logic       sclk, mosi;

	// two flip-flops on the data pin
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			miso_m <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			miso_m <= I_TARGET_MISO;
			miso_s <= miso_m;
		end
	end

	sth_shifter u_shf (
		.i_clk       (I_CLK_SYS),
		.i_arst_n    (I_ARST_N),
		.i_half_div  (st.div),
		.i_miso_sync (miso_s),
		.o_sclk      (sclk),
		.o_mosi      (mosi),
		.lnk         (lnk)
	);

	assign lnk.start   = st.start;
	assign lnk.tx_byte = st.txb;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				old[8*b +: 8] = d[8*b +: 8];
			end
		end
		return old;
	endfunction : merge

	// counts of bytes on the frame
	logic [2:0] n_adr;
	logic [3:0] n_dat;
	logic [3:0] n_stat;
	logic [5:0] n_rd;
	logic [3:0] n_wait;
	logic [3:0] n_send;
	logic [7:0] cmd;

	always_comb begin
		cmd    = st.ctrl[7:0];
		n_adr  = st.ctrl[CTRL_HASADR] ? {1'b0, st.ctrl[CTRL_ADRB_LO +: 2]} + 3'h1 : 3'h0;
		n_dat  = {1'b0, st.ctrl[CTRL_DATB_LO +: 3]};
		n_wait = st.ctrl[CTRL_WAIT_LO +: 4];
		if (cmd[7:4] == 4'h1 && n_wait == 4'h0) begin
			n_wait = 4'h1;
		end
		n_rd   = {2'b00, st.ctrl[CTRL_RDB_LO +: 4]};
		if (cmd[7] && !st.ctrl[CTRL_EXT]) begin
			n_rd = (cmd[5] || cmd[6]) ? {sth_block_words(cmd), 2'b00} : 6'h00;
		end
		n_stat = st.ctrl[CTRL_STAT] && !st.ctrl[CTRL_POSTED] ? 4'h2 : 4'h0;
		if (cmd == CMD_POLL_FULL) begin
			n_stat = 4'h4;
		end
		n_send = (st.ctrl[CTRL_EXT] ? 4'h2 : 4'h1) + {1'b0, n_adr} + n_dat;
	end

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		// ****************************************************
		// register slave
		// ****************************************************
		if (I_AWVALID && !st.aw_ok) begin
			next_st.aw_ok = 1'b1;
			next_st.awa   = I_AWADDR;
		end
		if (I_WVALID && !st.w_ok) begin
			next_st.w_ok = 1'b1;
			next_st.wd   = I_WDATA;
			next_st.ws   = I_WSTRB;
		end
		if (st.aw_ok && st.w_ok && !st.bvalid) begin
			next_st.aw_ok  = 1'b0;
			next_st.w_ok   = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = RESP_OKAY;
			unique case (st.awa)
				REG_CTRL: begin
					if (st.ph == PH_IDLE && st.init) begin
						next_st.ctrl = merge(st.ctrl, st.wd, st.ws);
					end else begin
						next_st.bresp = RESP_SLVERR;
					end
				end
				REG_ADDR:  next_st.addr  = merge(st.addr, st.wd, st.ws);
				REG_WDATA: next_st.wdata = merge(st.wdata, st.wd, st.ws);
				REG_DIV: begin
					next_st.div = merge({24'h0, st.div}, st.wd, st.ws) == 32'h0 ?
						8'h01 : st.wd[7:0];
				end
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end
		if (st.bvalid && I_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		if (I_ARVALID && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			unique case (I_ARADDR)
				REG_CTRL:   next_st.rd = st.ctrl;
				REG_ADDR:   next_st.rd = st.addr;
				REG_WDATA:  next_st.rd = st.wdata;
				REG_STATUS: next_st.rd = {28'h0, st.init, st.done, st.ph != PH_IDLE, 1'b0};
				REG_TSTAT:  next_st.rd = st.tstat;
				REG_RDATA:  next_st.rd = st.rdata;
				REG_DIV:    next_st.rd = {24'h0, st.div};
				default: begin
					next_st.rd    = SLAVE_ERR;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && I_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		// ****************************************************
		// frame sequencer
		// ****************************************************
		unique case (st.ph)
			PH_IDLE: begin
				if (!st.init) begin
					next_st.ctrl  = {1'b1, 2'b00, 1'b1, 1'b1, 3'h0, 8'h01,
						4'h0, 4'(STARTUP_WAITS), CMD_LREG_WR_BYTE};
					next_st.addr  = {24'h0, ADDR_EMB_STATUS};
					next_st.wdata = {24'h0, FLAG_CLEAR_VALUE};
					next_st.init  = 1'b1;
				end else if (st.ctrl[CTRL_GO]) begin
					next_st.ph    = PH_SEND;
					next_st.sel_n = 1'b0;
					next_st.idx   = 4'h0;
					next_st.done  = 1'b0;
					next_st.tstat = 32'h0;
					next_st.rdata = 32'h0;
					next_st.start = 1'b1;
					next_st.txb   = st.ctrl[CTRL_EXT] ? CMD_EXTEND_CODE : cmd;
				end
			end
			PH_SEND: begin
				if (lnk.done) begin
					next_st.idx = st.idx + 4'h1;
					if (st.idx + 4'h1 < n_send) begin
						next_st.start = 1'b1;
						if (st.ctrl[CTRL_EXT] && st.idx == 4'h0) begin
							next_st.txb = cmd;
						end else if (st.idx + 4'h1 < n_send - n_dat) begin
							next_st.txb = st.addr[8*(n_send - st.idx - 4'h2 - n_dat) +: 8];
						end else begin
							next_st.txb = st.wdata[8*(n_send - st.idx - 4'h2) +: 8];
						end
					end else if (st.ctrl[CTRL_POSTED] ||
						(n_wait == 4'h0 && n_stat == 4'h0 && n_rd == 6'h00)) begin
						next_st.ph = PH_END;
					end else begin
						next_st.ph    = PH_RECV;
						next_st.rcnt  = 6'h0;
						next_st.start = 1'b1;
						next_st.txb   = 8'h00;
					end
				end
			end
			PH_RECV: begin
				if (lnk.done) begin
					next_st.rcnt = st.rcnt + 6'h1;
					if (st.rcnt < {2'b00, n_wait}) begin
						next_st.tstat[7:0] = lnk.rx_byte;
					end else if (st.rcnt < {2'b00, n_wait} + {2'b00, n_stat}) begin
						next_st.tstat = {lnk.rx_byte, st.tstat[31:8]};
					end else begin
						next_st.rdata = {lnk.rx_byte, st.rdata[31:8]};
					end
					if (st.rcnt + 6'h1 < {2'b00, n_wait} + {2'b00, n_stat} + n_rd) begin
						next_st.start = 1'b1;
					end else begin
						next_st.ph = PH_END;
					end
				end
			end
			PH_END: begin
				if (!lnk.busy && !st.start) begin
					next_st.sel_n = 1'b1;
					next_st.ph    = PH_IDLE;
					next_st.done  = 1'b1;
					next_st.ctrl[CTRL_GO] = 1'b0;
				end
			end
			default: next_st.ph = PH_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st       <= '0;
			st.sel_n <= 1'b1;
			st.div   <= DIV_RESET;
			st.ph    <= PH_IDLE;
		end else begin
			st <= next_st;
		end
	end

	logic sclk_q, mosi_q;
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			mosi_q <= mosi;
		end
	end

	assign O_AWREADY             = !st.aw_ok;
	assign O_WREADY              = !st.w_ok;
	assign O_BVALID              = st.bvalid;
	assign O_BRESP               = st.bresp;
	assign O_ARREADY             = !st.rvalid;
	assign O_RVALID              = st.rvalid;
	assign O_RRESP               = st.rresp;
	assign O_RDATA               = st.rd;
	assign O_TARGET_SELECT_N     = st.sel_n;
	assign O_TARGET_SERIAL_CLOCK = sclk_q;
	assign O_TARGET_MOSI         = mosi_q;
	assign O_BUSY                = st.ph != PH_IDLE;

endmodule : sth_host

/* File: rtl/sth_link_if.sv */
// interface between frame sequencer and serial shifter
`timescale 1ns/100ps
interface sth_link_if;
	logic       start;
	logic [7:0] tx_byte;
	logic       busy;
	logic       done;
	logic [7:0] rx_byte;

	modport seq (output start, output tx_byte, input busy, input done, input rx_byte);
	modport shf (input start, input tx_byte, output busy, output done, output rx_byte);
endinterface : sth_link_if

/* File: rtl/sth_pkg.sv */
// package of constants and types for the serial target host controller
package sth_pkg;

	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [7:0] CMD_OPEN_WORD_WR   = 8'h01;
	localparam logic [7:0] CMD_OPEN_BYTE_WR   = 8'h02;
	localparam logic [7:0] CMD_OPEN_WORD_RD   = 8'h05;
	localparam logic [7:0] CMD_OPEN_BYTE_RD   = 8'h06;
	localparam logic [7:0] CMD_CLEAR_RX       = 8'h12;
	localparam logic [7:0] CMD_CLEAR_TX       = 8'h14;
	localparam logic [7:0] CMD_CLEAR_BOTH     = 8'h16;
	localparam logic [7:0] CMD_LREG_WR_BYTE   = 8'h09;
	localparam logic [7:0] CMD_LREG_WR_HALF   = 8'h0A;
	localparam logic [7:0] CMD_LREG_WR_WORD   = 8'h0B;
	localparam logic [7:0] CMD_LREG_RD_BYTE   = 8'h0D;
	localparam logic [7:0] CMD_LREG_RD_HALF   = 8'h0E;
	localparam logic [7:0] CMD_LREG_RD_WORD   = 8'h0F;
	localparam logic [7:0] CMD_MEM_WR_BYTE    = 8'h21;
	localparam logic [7:0] CMD_MEM_WR_HALF    = 8'h22;
	localparam logic [7:0] CMD_MEM_WR_WORD    = 8'h23;
	localparam logic [7:0] CMD_MEM_RD_BYTE    = 8'h25;
	localparam logic [7:0] CMD_MEM_RD_HALF    = 8'h26;
	localparam logic [7:0] CMD_MEM_RD_WORD    = 8'h27;
	localparam logic [7:0] CMD_Q_RD_BYTE      = 8'h28;
	localparam logic [7:0] CMD_Q_RD_HALF      = 8'h29;
	localparam logic [7:0] CMD_Q_RD_WORD      = 8'h2B;
	localparam logic [7:0] CMD_Q_RD_BYTE_STAT = 8'h68;
	localparam logic [7:0] CMD_Q_RD_HALF_STAT = 8'h69;
	localparam logic [7:0] CMD_Q_RD_WORD_STAT = 8'h6B;
	localparam logic [7:0] CMD_POLL_LO        = 8'h2C;
	localparam logic [7:0] CMD_POLL_HI        = 8'h2D;
	localparam logic [7:0] CMD_POLL_FULL      = 8'h2F;
	localparam logic [7:0] CMD_EXTEND_CODE    = 8'h6C;
	localparam logic [7:0] CMD_MEM_BLK_WR     = 8'h80;
	localparam logic [7:0] CMD_MEM_BLK_RD     = 8'hA0;
	localparam logic [7:0] CMD_Q_BLK_RD       = 8'hC0;
	localparam logic [7:0] CMD_Q_BLK_RD_STAT  = 8'hE0;

	// ************************************************************
	// device map and start-up values
	// ************************************************************
	localparam logic [7:0]  ADDR_EMB_STATUS   = 8'h04;
	localparam logic [7:0]  FLAG_CLEAR_VALUE  = 8'h06;
	localparam int          STARTUP_WAITS     = 4;
	localparam int          ADDR_REGION_BIT   = 15;
	localparam logic [31:0] CFG_ACTIVATE      = 32'h0001_0000;
	localparam logic [31:0] CFG_LOCK_ALL      = 32'h0001_04CE;
	localparam logic [31:0] CFG_LOCK_MEM      = 32'h0001_00C0;
	localparam logic [31:0] CFG_HIDE_LOCAL    = 32'h0003_0000;

	// ************************************************************
	// own register offsets (byte addresses)
	// ************************************************************
	localparam logic [5:0] REG_CTRL    = 6'h00;
	localparam logic [5:0] REG_ADDR    = 6'h04;
	localparam logic [5:0] REG_WDATA   = 6'h08;
	localparam logic [5:0] REG_STATUS  = 6'h0C;
	localparam logic [5:0] REG_TSTAT   = 6'h10;
	localparam logic [5:0] REG_RDATA   = 6'h14;
	localparam logic [5:0] REG_DIV     = 6'h18;

	// ctrl fields
	localparam int CTRL_GO      = 31;
	localparam int CTRL_EXT     = 30;
	localparam int CTRL_POSTED  = 29;
	localparam int CTRL_STAT    = 28;
	localparam int CTRL_HASADR  = 27;
	localparam int CTRL_ADRB_LO = 24;
	localparam int CTRL_DATB_LO = 16;
	localparam int CTRL_RDB_LO  = 12;
	localparam int CTRL_WAIT_LO = 8;

	localparam logic [7:0]  DIV_RESET    = 8'h04;
	localparam logic [31:0] SLAVE_ERR    = 32'hDEAD_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_SEND,
		PH_RECV,
		PH_END
	} sth_phase_t;

	// block commands carry length in the low three bits
	function automatic logic [3:0] sth_block_words(input logic [7:0] cmd);
		sth_block_words = {1'b0, cmd[2:0]} + 4'h1;
	endfunction : sth_block_words

endpackage : sth_pkg

/* File: rtl/sth_shifter.sv */
// byte shifter that makes the serial clock by division, mode 0
`timescale 1ns/100ps
module sth_shifter
	import sth_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_arst_n,
	input  wire logic [7:0] i_half_div,
	input  wire logic  i_miso_sync,
	output logic       o_sclk,
	output logic       o_mosi,
	sth_link_if.shf    lnk
);

	typedef struct packed {
		logic       busy;
		logic       done;
		logic [7:0] cnt;
		logic [3:0] bits;
		logic       sclk;
		logic [7:0] sh;
		logic [7:0] rx;
	} sth_shf_t;

	sth_shf_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (!st.busy) begin
			if (lnk.start) begin
				next_st.busy = 1'b1;
				next_st.sh   = lnk.tx_byte;
				next_st.cnt  = 8'h00;
				next_st.bits = 4'h0;
			end
		end else if (st.cnt + 8'h01 >= i_half_div) begin
			next_st.cnt  = 8'h00;
			next_st.sclk = ~st.sclk;
			if (!st.sclk) begin
				next_st.rx = {st.rx[6:0], i_miso_sync};
			end else begin
				next_st.sh   = {st.sh[6:0], 1'b0};
				next_st.bits = st.bits + 4'h1;
				if (st.bits == 4'h7) begin
					next_st.busy = 1'b0;
					next_st.done = 1'b1;
				end
			end
		end else begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sclk      = st.sclk;
	assign o_mosi      = st.sh[7];
	assign lnk.busy    = st.busy;
	assign lnk.done    = st.done;
	assign lnk.rx_byte = st.rx;

endmodule : sth_shifter

/* File: verif/sth_host_monitor.sv */
// checker for bus answers and serial pin timing of the host controller
`timescale 1ns/100ps
module sth_host_monitor
	import sth_pkg::*;
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_ARST_N,
	input wire logic        I_AWVALID,
	input wire logic        O_AWREADY,
	input wire logic        I_WVALID,
	input wire logic        O_WREADY,
	input wire logic [1:0]  O_BRESP,
	input wire logic        O_BVALID,
	input wire logic        I_BREADY,
	input wire logic [5:0]  I_ARADDR,
	input wire logic        I_ARVALID,
	input wire logic        O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic        O_RVALID,
	input wire logic        I_RREADY,
	input wire logic        O_TARGET_SELECT_N,
	input wire logic        O_TARGET_SERIAL_CLOCK,
	input wire logic        O_TARGET_MOSI,
	input wire logic        O_BUSY
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);

	sequence s_wr_taken;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_rd_taken;
		I_ARVALID && O_ARREADY;
	endsequence

	a_bvalid_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write answer dropped early");
	a_rvalid_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read answer dropped early");
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] O_BVALID)
		else $error("no write answer");
	a_read_answer: assert property (s_rd_taken |-> ##[1:3] O_RVALID)
		else $error("no read answer");
	a_unmapped_read: assert property ((s_rd_taken ##0 I_ARADDR == 6'h3C)
		|-> ##[1:3] (O_RVALID && O_RDATA == SLAVE_ERR))
		else $error("unmapped read data wrong");
	a_idle_clock_low: assert property (O_TARGET_SELECT_N |-> !O_TARGET_SERIAL_CLOCK)
		else $error("serial clock high outside frame");
	a_mosi_steady: assert property (O_TARGET_SERIAL_CLOCK |-> $stable(O_TARGET_MOSI))
		else $error("host data moved while clock high");
	a_busy_frame: assert property (!O_TARGET_SELECT_N |-> O_BUSY)
		else $error("frame open without busy");
endmodule : sth_host_monitor

bind sth_host sth_host_monitor mon (.I_CLK_SYS, .I_ARST_N, .I_AWVALID, .O_AWREADY, .I_WVALID,
	.O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
	.O_RVALID, .I_RREADY, .O_TARGET_SELECT_N, .O_TARGET_SERIAL_CLOCK, .O_TARGET_MOSI, .O_BUSY);

/* File: verif/sth_host_tb_top.sv */
// testbench for the serial target host controller
`timescale 1ns/100ps
module sth_host_tb_top
	import sth_pkg::*;
;
	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam logic [31:0] ST = 32'h5A3C_0081;
	logic        clk, rst_n, awv, wv, bready, arv, rready, miso, sel_n, sclk, mosi, busy;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, ts, rdat;
	logic [1:0]  r, bresp, rresp;
	int          n_fail, cmp_count, n;

	sth_host uut (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awv),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wready),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
		.I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready), .I_TARGET_MISO(miso), .O_TARGET_SELECT_N(sel_n),
		.O_TARGET_SERIAL_CLOCK(sclk), .O_TARGET_MOSI(mosi), .O_BUSY(busy));
	sth_target_model #(.STAT(ST)) model (.i_sel_n(sel_n), .i_sclk(sclk), .i_mosi(mosi),
		.o_miso(miso));

	always #50 clk = ~clk;

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic results;
		if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [31:0] dd, output logic [1:0] rr);
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= dd;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (awready === 1'b1) awv <= 1'b0;
			if (wready === 1'b1) wv <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		rr = bresp;
		bready <= 1'b0;
		if (k == 100) begin n_fail++; results(); end
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] dd, output logic [1:0] rr);
		int k;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (arready === 1'b1) arv <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		dd = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (k == 100) begin n_fail++; results(); end
	endtask : rd

	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 3000; k++) begin
			rd(REG_STATUS, d, r);
			if ((d & m) === v) break;
		end
		if (k == 3000) begin n_fail++; results(); end
	endtask : wait_st

	task automatic run(input logic [31:0] a, input logic [31:0] wd, input logic [31:0] ctl);
		wr(REG_ADDR, a, r);
		wr(REG_WDATA, wd, r);
		wr(REG_CTRL, ctl, r);
		chk(32'(r), 32'(RESP_OKAY));
		wait_st(32'h6, 32'h4);
		rd(REG_TSTAT, ts, r);
		rd(REG_RDATA, rdat, r);
	endtask : run

	function automatic logic [31:0] c(input logic [7:0] cm, input logic [3:0] w,
		input logic [3:0] rb, input logic [2:0] db, input logic [1:0] ab, input logic [4:0] fl);
		c = {fl, 1'b0, ab, 5'h00, db, rb, w, cm};
	endfunction : c

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		{clk, rst_n, awv, wv, bready, arv, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		n_fail = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wait_st(32'hE, 32'hC);
		chk(model.embedded_side_status, 32'h0);
		rd(6'h3C, d, r);
		chk(d, SLAVE_ERR);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(6'h3C, 32'h0, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(REG_DIV, d, r);
		chk(32'(d[7:0]), 32'(DIV_RESET));
		run(32'h04, 32'h0, c(CMD_LREG_RD_WORD, 4'h4, 4'h4, 3'h0, 2'h0, 5'b10011));
		chk(rdat, 32'h0);
		chk(32'(ts[31:16]), 32'(ST[15:0]));
		for (n = 0; n < 2; n++) begin
			run({n[0], 15'h10}, 32'h1122_3344 + n, c(CMD_MEM_WR_WORD, 4'h4, 4'h0, 3'h4, 2'h1, 5'b10011));
			chk(32'(ts[31:16]), 32'(ST[15:0]));
		end
		for (n = 0; n < 2; n++) begin
			run({n[0], 15'h10}, 32'h0, c(CMD_MEM_RD_WORD, 4'h4, 4'h4, 3'h0, 2'h1, 5'b10011));
			chk(rdat, 32'h1122_3344 + n);
		end
		run(32'h10, 32'hA5A5_0F0F, c(CMD_MEM_WR_WORD, 4'h0, 4'h0, 3'h4, 2'h1, 5'b10101));
		chk(model.last, 7);
		run(32'h10, 32'h0, c(CMD_MEM_RD_WORD, 4'h0, 4'h0, 3'h0, 2'h1, 5'b10101));
		chk(model.last, 3);
		run(32'h0, 32'h0, c(CMD_POLL_LO, 4'h0, 4'h0, 3'h0, 2'h0, 5'b10010));
		chk(32'(ts[31:16]), 32'(ST[15:0]));
		run(32'h0, 32'h0, c(CMD_Q_RD_WORD_STAT, 4'h0, 4'h4, 3'h0, 2'h0, 5'b10010));
		chk(rdat, 32'hA5A5_0F0F);
		chk(32'(ts[31:16]), 32'(ST[15:0]));
		run(32'h0, 32'h0, c(CMD_POLL_HI, 4'h0, 4'h0, 3'h0, 2'h0, 5'b10010));
		chk(32'(ts[31:16]), 32'(ST[31:16]));
		run(32'h0, 32'h0, c(CMD_POLL_FULL, 4'h0, 4'h0, 3'h0, 2'h0, 5'b10010));
		chk(ts, ST);
		run(32'h0, 32'h0, c(CMD_CLEAR_BOTH, 4'h0, 4'h0, 3'h0, 2'h0, 5'b10000));
		chk(32'(model.clr_ok), 32'h1);
		run(32'h20, 32'h0102_0304, c(CMD_OPEN_WORD_WR, 4'h0, 4'h0, 3'h4, 2'h1, 5'b11101));
		chk(32'(model.cmd), 32'(CMD_OPEN_WORD_WR));
		chk(model.last, 8);
		run(32'h20, 32'h0, c(CMD_OPEN_WORD_RD, 4'h0, 4'h4, 3'h0, 2'h1, 5'b11011));
		chk(32'(ts[31:16]), 32'(ST[15:0]));
		chk(rdat, 32'hA5A5_0F0F);
		run(32'h0, 32'h0, c(CMD_Q_BLK_RD_STAT, 4'h0, 4'h0, 3'h0, 2'h0, 5'b10010));
		chk(rdat, 32'hA5A5_0F0F);
		results();
	end
endmodule : sth_host_tb_top

/* File: verif/sth_target_model.sv */
// behavioural model of the serial target seen by the host controller
`timescale 1ns/100ps
module sth_target_model
	import sth_pkg::*;
#(
	parameter int          WAITS = 4,
	parameter logic [31:0] STAT  = 32'h5A3C_0081
)(
	input  wire logic i_sel_n,
	input  wire logic i_sclk,
	input  wire logic i_mosi,
	output logic      o_miso
);
	// ************************************************************
	// frame decoding
	// ************************************************************
	logic [7:0]  cmd = 8'h00, sh, tx;
	logic [15:0] adr;
	logic [31:0] embedded_side_status = 32'h0000_0006, rd, q, acc, mem [2];
	logic        ext, clr_ok, wrc;
	int          nb, bit_n, last;

	task automatic take(input logic [7:0] b);
		int k, al, dl, rr;
		if (nb == 0 && b == CMD_EXTEND_CODE) ext = 1'b1;
		k = nb - int'(ext);
		nb++;
		if (k == 0) cmd = b;
		al = (cmd[7:3] == 5'h01) ? 1 : ((cmd[7:4] == 4'h2 && !cmd[3]) || ext) ? 2 : 0;
		wrc = !cmd[2] && al > 0;
		dl = (wrc && !ext) ? ((cmd[1:0] == 2'h3) ? 4 : int'(cmd[1:0])) : 0;
		if (k >= 1 && k <= al) adr = {adr[7:0], b};
		else if (k > al && k <= al + dl) acc = {acc[23:0], b};
		if (k > 0 && k == al + dl && !ext) begin
			if (wrc && al == 1 && adr[7:0] == ADDR_EMB_STATUS)
				embedded_side_status = embedded_side_status & ~acc;
			else if (wrc) mem[adr[15]] = acc;
			rd = (al == 1) ? embedded_side_status : mem[adr[15]];
			if (!wrc) q = rd;
		end
		rr = k - al - dl;
		if (cmd inside {CMD_POLL_LO, CMD_POLL_FULL}) tx = 8'(STAT >> (8 * rr));
		else if (cmd == CMD_POLL_HI) tx = 8'(STAT >> (16 + 8 * rr));
		else if (cmd[6:5] == 2'b11) tx = (rr < 2) ? 8'(STAT >> (8 * rr)) : 8'(q >> (8 * (rr - 2)));
		else if (al > 0 && !ext) tx = (rr < WAITS) ? STAT[7:0] :
			(rr < WAITS + 2) ? 8'(STAT >> (8 * (rr - WAITS))) : 8'(rd >> (8 * (rr - WAITS - 2)));
		else if (ext && !wrc) tx = (rr < 2) ? 8'(STAT >> (8 * rr)) : 8'(q >> (8 * (rr - 2)));
		else tx = 8'(nb * 37);
	endtask : take

	initial o_miso = 1'b0;
	always @(negedge i_sel_n) begin
		nb = 0;
		bit_n = 0;
		ext = 1'b0;
		tx = 8'hFF;
	end
	always @(posedge i_sclk) if (!i_sel_n) begin
		sh = {sh[6:0], i_mosi};
		bit_n++;
		if (bit_n % 8 == 0) take(sh);
	end
	always @(negedge i_sclk) if (!i_sel_n) o_miso = tx[7 - bit_n % 8];
	always @(posedge i_sel_n) begin
		last = nb;
		clr_ok = (cmd[7:4] == 4'h1) && bit_n > 8;
		o_miso = ~o_miso;
	end
endmodule : sth_target_model
